// ### hdl/lsw_ctrl.sv
// Segment LCD waveform controller with register port and frame interrupt
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module lsw_ctrl
   import lsw_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic external_osc_output_in,
   input wire logic alternate_clock_input_in,
   input wire logic wait_mode_in,
   input wire logic stop_mode_in,
   output logic [63:0] lcd_pin_out,
   output logic [63:0] pin_enable_bank_out,
   output logic [63:0] backplane_enable_bank_out,
   output logic lcd_drive_out,
   output logic frame_irq_out,
   output logic charge_pump_select_out,
   output logic pump_multiplier_select_out,
   output logic bias_buffer_bypass_out,
   output logic [1:0] supply_source_select_out,
   output logic [1:0] pump_clock_adjust_out
);
   // Clock input synchronisers
   logic [2:0] osc_s_q, osc_s_d;
   logic [2:0] alt_s_q, alt_s_d;
   logic osc_lvl_q, osc_lvl_d;
   logic alt_lvl_q, alt_lvl_d;
   logic osc_rise, alt_rise, lcd_tick;

   always_comb begin
      osc_s_d = {osc_s_q[1:0], external_osc_output_in};
      alt_s_d = {alt_s_q[1:0], alternate_clock_input_in};
      osc_lvl_d = (osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : osc_lvl_q;
      alt_lvl_d = (alt_s_q[1] == alt_s_q[2]) ? alt_s_q[2] : alt_lvl_q;
      osc_rise = osc_lvl_d & ~osc_lvl_q;
      alt_rise = alt_lvl_d & ~alt_lvl_q;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         osc_s_q <= 3'h0;
         alt_s_q <= 3'h0;
         osc_lvl_q <= 1'b0;
         alt_lvl_q <= 1'b0;
      end else begin
         osc_s_q <= osc_s_d;
         alt_s_q <= alt_s_d;
         osc_lvl_q <= osc_lvl_d;
         alt_lvl_q <= alt_lvl_d;
      end
   end

   // Register file
   logic [7:0] main_q, main_d;
   logic [7:0] power_q, power_d;
   logic [7:0] supply_q, supply_d;
   logic [7:0] blink_q, blink_d;
   logic status_q, status_d;
   logic mask_q, mask_d;
   logic [63:0] pen_q, pen_d;
   logic [63:0] bpen_q, bpen_d;
   logic [7:0] wf_q [PIN_N];
   logic [7:0] wf_d [PIN_N];
   logic [7:0] rdata_q, rdata_d;
   logic frame_pulse;
   logic hit_pen, hit_bpen, hit_wf;
   logic [2:0] bank;
   logic [5:0] wf_idx;

   always_comb begin
      main_d = main_q;
      power_d = power_q;
      supply_d = supply_q;
      blink_d = blink_q;
      mask_d = mask_q;
      pen_d = pen_q;
      bpen_d = bpen_q;
      wf_d = wf_q;
      bank = reg_addr_in[BANK_W-1:0];
      wf_idx = reg_addr_in[WF_IDX_W-1:0];
      hit_pen = reg_addr_in[6:BANK_W] == PIN_EN_BASE[6:BANK_W];
      hit_bpen = reg_addr_in[6:BANK_W] == BP_EN_BASE[6:BANK_W];
      hit_wf = reg_addr_in[6] == WF_BASE[6];
      if (reg_wr_in) begin
         if (reg_addr_in == MAIN_CTRL_OFS) begin
            main_d = reg_wdata_in;
         end
         if (reg_addr_in == POWER_CTRL_OFS) begin
            power_d = {5'h00, reg_wdata_in[2:0]};
         end
         if (reg_addr_in == SUPPLY_CTRL_OFS) begin
            supply_d = reg_wdata_in & 8'hf7;
         end
         if (reg_addr_in == BLINK_CTRL_OFS) begin
            blink_d = reg_wdata_in & 8'hef;
         end
         if (reg_addr_in == IRQ_MASK_OFS) begin
            mask_d = reg_wdata_in[FRAME_FLAG_BIT];
         end
         if (hit_pen) begin
            pen_d[{bank, 3'h0} +: 8] = reg_wdata_in;
         end
         if (hit_bpen) begin
            bpen_d[{bank, 3'h0} +: 8] = reg_wdata_in;
         end
         if (hit_wf) begin
            wf_d[wf_idx] = reg_wdata_in;
         end
      end
      // Frame flag: a new frame beats a read clear
      status_d = status_q;
      if (reg_rd_in && reg_addr_in == IRQ_STATUS_OFS) begin
         status_d = 1'b0;
      end
      if (frame_pulse) begin
         status_d = 1'b1;
      end
      rdata_d = REG_RESET;
      if (reg_rd_in) begin
         if (reg_addr_in == MAIN_CTRL_OFS) begin
            rdata_d = main_q;
         end else if (reg_addr_in == POWER_CTRL_OFS) begin
            rdata_d = power_q;
         end else if (reg_addr_in == SUPPLY_CTRL_OFS) begin
            rdata_d = supply_q;
         end else if (reg_addr_in == BLINK_CTRL_OFS) begin
            rdata_d = blink_q;
         end else if (reg_addr_in == IRQ_STATUS_OFS) begin
            rdata_d = {7'h00, status_q};
         end else if (reg_addr_in == IRQ_MASK_OFS) begin
            rdata_d = {7'h00, mask_q};
         end else if (hit_pen) begin
            rdata_d = pen_q[{bank, 3'h0} +: 8];
         end else if (hit_bpen) begin
            rdata_d = bpen_q[{bank, 3'h0} +: 8];
         end else if (hit_wf) begin
            rdata_d = wf_q[wf_idx];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         main_q <= REG_RESET;
         power_q <= REG_RESET;
         supply_q <= REG_RESET;
         blink_q <= REG_RESET;
         status_q <= 1'b0;
         mask_q <= 1'b0;
         pen_q <= 64'h0000_0000_0000_0000;
         bpen_q <= 64'h0000_0000_0000_0000;
         rdata_q <= REG_RESET;
         for (int i = 0; i < PIN_N; i++) begin
            wf_q[i] <= REG_RESET;
         end
      end else begin
         main_q <= main_d;
         power_q <= power_d;
         supply_q <= supply_d;
         blink_q <= blink_d;
         status_q <= status_d;
         mask_q <= mask_d;
         pen_q <= pen_d;
         bpen_q <= bpen_d;
         rdata_q <= rdata_d;
         wf_q <= wf_d;
      end
   end

   // Field views
   logic module_en, clk_src, irq_en, wait_dis, stop_dis;
   logic [2:0] prescale, duty, blink_rate;
   logic blink_en, alt_bit, blank_bit, blink_style;
   logic run;

   always_comb begin
      module_en = main_q[MODULE_EN_BIT];
      clk_src = main_q[CLK_SRC_BIT];
      prescale = main_q[PRESCALE_LSB +: 3];
      duty = main_q[DUTY_LSB +: 3];
      irq_en = power_q[IRQ_EN_BIT];
      wait_dis = power_q[WAIT_DIS_BIT];
      stop_dis = power_q[STOP_DIS_BIT];
      blink_en = blink_q[BLINK_EN_BIT];
      alt_bit = blink_q[ALT_BIT];
      blank_bit = blink_q[BLANK_BIT];
      blink_style = blink_q[BLINK_STYLE_BIT];
      blink_rate = blink_q[BLINK_RATE_LSB +: 3];
      lcd_tick = clk_src ? alt_rise : osc_rise;
      // Settings are taken as stable while enabled
      run = module_en & ~(wait_mode_in & wait_dis)
         & ~(stop_mode_in & stop_dis);
   end

   // Phase and blink timing
   logic [7:0] tick_cnt_q, tick_cnt_d;
   logic [2:0] phase_q, phase_d;
   logic [18:0] blink_cnt_q, blink_cnt_d;
   logic [7:0] phase_ticks;
   logic phase_end, blink_half;

   always_comb begin
      phase_ticks = {4'h0, {1'b0, prescale} + 4'h1} << PHASE_SHIFT;
      phase_end = lcd_tick && (tick_cnt_q >= phase_ticks - 8'h01);
      frame_pulse = run && phase_end && (phase_q >= duty);
      tick_cnt_d = tick_cnt_q;
      phase_d = phase_q;
      blink_cnt_d = blink_cnt_q;
      if (!run) begin
         tick_cnt_d = 8'h00;
         phase_d = 3'h0;
         blink_cnt_d = 19'h0_0000;
      end else if (lcd_tick) begin
         blink_cnt_d = blink_cnt_q + 19'h0_0001;
         if (phase_end) begin
            tick_cnt_d = 8'h00;
            phase_d = (phase_q >= duty) ? 3'h0 : phase_q + 3'h1;
         end else begin
            tick_cnt_d = tick_cnt_q + 8'h01;
         end
      end
      blink_half = blink_en
         & blink_cnt_q[5'(blink_rate) + 5'(BLINK_SHIFT)];
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_cnt_q <= 8'h00;
         phase_q <= 3'h0;
         blink_cnt_q <= 19'h0_0000;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         phase_q <= phase_d;
         blink_cnt_q <= blink_cnt_d;
      end
   end

   // Pin waveforms
   logic [63:0] pins_q, pins_d;
   logic drive_q, drive_d;
   logic blank_view, alt_view;
   logic [2:0] seg_phase;
   logic [63:0] bp_mask, seg_mask;

   always_comb begin
      blank_view = blank_bit | (blink_half & ~blink_style);
      alt_view = alt_bit | (blink_half & blink_style);
      seg_phase = alt_view ? (phase_q ^ ALT_PHASE_XOR) : phase_q;
      bp_mask = pen_q & bpen_q;
      seg_mask = pen_q & ~bpen_q;
      drive_d = run;
      for (int i = 0; i < PIN_N; i++) begin
         pins_d[i] = 1'b0;
         if (run && bp_mask[i]) begin
            pins_d[i] = wf_q[i][phase_q];
         end else if (run && seg_mask[i] && !blank_view) begin
            pins_d[i] = wf_q[i][seg_phase];
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pins_q <= 64'h0000_0000_0000_0000;
         drive_q <= 1'b0;
      end else begin
         pins_q <= pins_d;
         drive_q <= drive_d;
      end
   end

   // Outputs
   assign reg_rdata_out = rdata_q;
   assign lcd_pin_out = pins_q;
   assign pin_enable_bank_out = pen_q;
   assign backplane_enable_bank_out = bp_mask;
   assign lcd_drive_out = drive_q;
   assign frame_irq_out = irq_en & mask_q & status_q;
   assign charge_pump_select_out = supply_q[PUMP_SEL_BIT];
   assign pump_multiplier_select_out = supply_q[PUMP_MULT_BIT];
   assign bias_buffer_bypass_out = supply_q[BUF_BYPASS_BIT];
   assign supply_source_select_out = supply_q[SUPPLY_LSB +: 2];
   assign pump_clock_adjust_out = supply_q[PUMP_ADJ_LSB +: 2];

   // Checks
   irq_gate_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) !irq_en |-> !frame_irq_out)
      else $error("frame interrupt raised while disabled");
   clk_source_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (run && !(clk_src ? alt_rise : osc_rise))
      |=> ($stable(tick_cnt_q) || !run))
      else $error("timing advanced without selected clock edge");
   duty_wrap_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (run && phase_end && phase_q >= duty)
      |=> (phase_q == 3'h0))
      else $error("phase did not wrap at duty end");
   phase_len_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in)
      (run && lcd_tick && tick_cnt_q < phase_ticks - 8'h01)
      |=> $stable(phase_q))
      else $error("phase ended before prescaled length");
   blink_gate_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) !blink_en |-> !blink_half)
      else $error("blink active while blink disabled");
   blank_style_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (blink_half && !blink_style)
      |=> ((lcd_pin_out & $past(seg_mask)) == 64'h0000_0000_0000_0000))
      else $error("segments driven in blank half");
   blink_rate_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (blink_en && $past(blink_en)
      && $stable(blink_rate) && run && $past(run) && !$past(lcd_tick))
      |-> $stable(blink_half))
      else $error("blink phase moved without clock edge");
   wait_on_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (module_en && !wait_dis && wait_mode_in
      && !stop_mode_in) |=> lcd_drive_out)
      else $error("display stopped in wait mode");
   stop_off_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (stop_mode_in && stop_dis) |=>
      (!lcd_drive_out && lcd_pin_out == 64'h0000_0000_0000_0000))
      else $error("display driven in stop mode");
   pin_enable_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in)
      1'b1 |=> ((lcd_pin_out & ~$past(pen_q)) == 64'h0000_0000_0000_0000))
      else $error("disabled pin driven");
   backplane_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) (run && bp_mask[0])
      |=> (lcd_pin_out[0] == $past(wf_q[0][phase_q])))
      else $error("backplane phase mismatch");
   enable_gate_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) !module_en |-> (!frame_pulse ##1
      (!lcd_drive_out && lcd_pin_out == 64'h0000_0000_0000_0000)))
      else $error("waveform generated while module disabled");
   frame_flag_a: assert property (@(posedge mclk_in)
      disable iff (!rstn_in) frame_pulse |=> status_q)
      else $error("frame flag not set at frame end");
endmodule : lsw_ctrl

// ### hdl/lsw_pkg.sv
// Constants of the segment LCD waveform controller
package lsw_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PIN_N = 64;
   localparam int unsigned PHASE_N = 8;
   localparam int unsigned PHASE_W = 3;
   localparam int unsigned BANK_W = 3;
   localparam int unsigned WF_IDX_W = 6;
   // Register offsets
   localparam logic [6:0] MAIN_CTRL_OFS = 7'h00;
   localparam logic [6:0] POWER_CTRL_OFS = 7'h01;
   localparam logic [6:0] SUPPLY_CTRL_OFS = 7'h02;
   localparam logic [6:0] BLINK_CTRL_OFS = 7'h03;
   localparam logic [6:0] IRQ_STATUS_OFS = 7'h04;
   localparam logic [6:0] IRQ_MASK_OFS = 7'h05;
   localparam logic [6:0] PIN_EN_BASE = 7'h08;
   localparam logic [6:0] BP_EN_BASE = 7'h10;
   localparam logic [6:0] WF_BASE = 7'h40;
   // Main control fields
   localparam int unsigned MODULE_EN_BIT = 7;
   localparam int unsigned CLK_SRC_BIT = 6;
   localparam int unsigned PRESCALE_LSB = 3;
   localparam int unsigned DUTY_LSB = 0;
   // Power mode fields
   localparam int unsigned IRQ_EN_BIT = 2;
   localparam int unsigned WAIT_DIS_BIT = 1;
   localparam int unsigned STOP_DIS_BIT = 0;
   // Supply fields
   localparam int unsigned PUMP_SEL_BIT = 7;
   localparam int unsigned PUMP_MULT_BIT = 6;
   localparam int unsigned PUMP_ADJ_LSB = 4;
   localparam int unsigned BUF_BYPASS_BIT = 2;
   localparam int unsigned SUPPLY_LSB = 0;
   // Blink fields
   localparam int unsigned BLINK_EN_BIT = 7;
   localparam int unsigned ALT_BIT = 6;
   localparam int unsigned BLANK_BIT = 5;
   localparam int unsigned BLINK_STYLE_BIT = 3;
   localparam int unsigned BLINK_RATE_LSB = 0;
   // Frame flag position in status and mask
   localparam int unsigned FRAME_FLAG_BIT = 0;
   // Timing
   localparam int unsigned PHASE_SHIFT = 4;
   localparam int unsigned BLINK_SHIFT = 11;
   localparam int unsigned BLINK_CNT_W = 19;
   localparam logic [2:0] ALT_PHASE_XOR = 3'h4;
   localparam logic [7:0] REG_RESET = 8'h00;
endpackage : lsw_pkg

// ### testbench/lsw_ctrl_tb.sv
// Self-checking bench of the segment LCD controller
`timescale 1ns/100ps
module lsw_ctrl_tb;
   import lsw_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic osc = 1'b0, alternate_display_bit = 1'b0, osc_on = 1'b0, alt_on = 1'b0;
   logic wt = 1'b0, st = 1'b0, clr = 1'b0;
   logic [6:0] addr = '0;
   logic [7:0] wdata = '0;
   logic [7:0] rdata, r1, r2, r3;
   logic [63:0] pins, pen, bpen, hi, lo;
   logic drive, irq, psel, pmul, byp;
   logic [1:0] sup, adj;
   int error_cnt = 0, compares = 0, cyc = 0, div_cnt = 0;
   logic [6:0] ofs [6] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05};
   logic [5:0] wp [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08,
      6'h09, 6'h3f};
   logic [7:0] wv [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'hff,
      8'h0f, 8'h01};
   logic [7:0] sv [3] = '{8'hc4, 8'h3a, 8'h00};
   logic [7:0] bv [3] = '{8'h80, 8'h88, 8'h08};
   logic [1:0] be [3] = '{2'b11, 2'b10, 2'b00};
   logic [3:0] ws [4] = '{4'hd, 4'h8, 4'h5, 4'h3};

   always #5 clk = ~clk;
   // Oscillator pins stepped on the bench clock
   always @(posedge clk) begin
      div_cnt <= div_cnt + 1;
      if (osc_on) begin
         osc <= div_cnt[1];
      end
      if (alt_on) begin
         alternate_display_bit <= (div_cnt % 5) < 2;
      end
   end

   lsw_ctrl i_dut (
      .mclk_in(clk), .rstn_in(rstn), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .external_osc_output_in(osc),
      .alternate_clock_input_in(alternate_display_bit), .wait_mode_in(wt),
      .stop_mode_in(st), .lcd_pin_out(pins),
      .pin_enable_bank_out(pen), .backplane_enable_bank_out(bpen),
      .lcd_drive_out(drive), .frame_irq_out(irq),
      .charge_pump_select_out(psel), .pump_multiplier_select_out(pmul),
      .bias_buffer_bypass_out(byp), .supply_source_select_out(sup),
      .pump_clock_adjust_out(adj)
   );
   lsw_glass i_glass (
      .mclk_in(clk), .rstn_in(rstn), .lcd_pin_in(pins),
      .drive_in(drive), .clear_in(clr), .hi_seen_out(hi),
      .lo_seen_out(lo)
   );

   task automatic tally_and_finish();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : tally_and_finish

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input string n, input logic [63:0] s,
      input logic [63:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk($sformatf("reg %h", a), 64'(d), 64'(e));
   endtask : rdc
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   // Clear the glass record, then watch n cycles
   task automatic watch(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      idle(n);
   endtask : watch

   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      foreach (ofs[i]) rdc(ofs[i], REG_RESET);
      rdc(7'h20, 8'h00);
      wr_reg(POWER_CTRL_OFS, 8'hff);
      rdc(POWER_CTRL_OFS, 8'h07);
      wr_reg(BLINK_CTRL_OFS, 8'hff);
      rdc(BLINK_CTRL_OFS, 8'hef);
      wr_reg(IRQ_MASK_OFS, 8'hff);
      rdc(IRQ_MASK_OFS, 8'h01);
      wr_reg(BLINK_CTRL_OFS, 8'h00);
      foreach (sv[i]) begin
         wr_reg(SUPPLY_CTRL_OFS, sv[i]);
         rdc(SUPPLY_CTRL_OFS, sv[i] & 8'hf7);
         chk("supply", {psel, pmul, adj, byp, sup},
            {sv[i][7:4], sv[i][2:0]});
      end
      wr_reg(PIN_EN_BASE, 8'hff);
      wr_reg(PIN_EN_BASE + 7'd1, 8'h03);
      wr_reg(PIN_EN_BASE + 7'd7, 8'h80);
      wr_reg(BP_EN_BASE, 8'h1f);
      wr_reg(BP_EN_BASE + 7'd2, 8'h01);
      wr_reg(BP_EN_BASE + 7'd7, 8'h80);
      idle(1);
      chk("pen", pen, 64'h8000_0000_0000_03ff);
      chk("bpen", bpen, 64'h8000_0000_0000_001f);
      foreach (wp[i]) wr_reg(WF_BASE + 7'(wp[i]), wv[i]);
      rdc(WF_BASE + 7'd9, 8'h0f);
      wr_reg(POWER_CTRL_OFS, 8'h00);
      wr_reg(MAIN_CTRL_OFS, 8'h03);
      osc_on = 1'b1;
      idle(300);
      chk("drive off", 64'(drive), 64'h0);
      chk("pins off", pins, 64'h0);
      wr_reg(MAIN_CTRL_OFS, 8'h83);
      idle(100);
      watch(2000);
      chk("duty4", hi, 64'h8000_0000_0000_030f);
      wr_reg(BLINK_CTRL_OFS, 8'h40);
      watch(2000);
      chk("alt", hi, 64'h8000_0000_0000_010f);
      wr_reg(BLINK_CTRL_OFS, 8'h20);
      watch(2000);
      chk("blank", hi, 64'h8000_0000_0000_000f);
      foreach (bv[i]) begin
         wr_reg(BLINK_CTRL_OFS, bv[i]);
         watch(9000);
         chk("blink", 64'(lo[9:8]), 64'(be[i]));
      end
      wr_reg(MAIN_CTRL_OFS, 8'h03);
      wr_reg(BLINK_CTRL_OFS, 8'h81);
      wr_reg(MAIN_CTRL_OFS, 8'h83);
      watch(10000);
      chk("rate", 64'(lo[9:8]), 64'h0);
      wr_reg(BLINK_CTRL_OFS, 8'h00);
      wr_reg(MAIN_CTRL_OFS, 8'h87);
      watch(3000);
      chk("duty8", hi, 64'h8000_0000_0000_031f);
      wr_reg(MAIN_CTRL_OFS, 8'h83);
      foreach (ws[i]) begin
         @(posedge clk);
         wt <= ws[i][3];
         st <= ws[i][2];
         wr_reg(POWER_CTRL_OFS, {6'h00, ws[i][1:0]});
         idle(3);
         chk("run", 64'(drive), 64'(ws[i][0] ^ ws[i][1] ^ 1'b1));
      end
      @(posedge clk);
      wt <= 1'b0;
      st <= 1'b0;
      wr_reg(POWER_CTRL_OFS, 8'h00);
      wr_reg(IRQ_MASK_OFS, 8'h01);
      rd_reg(IRQ_STATUS_OFS, r1);
      idle(600);
      chk("irq off", 64'(irq), 64'h0);
      rdc(IRQ_STATUS_OFS, 8'h01);
      wr_reg(POWER_CTRL_OFS, 8'h04);
      idle(600);
      chk("irq on", 64'(irq), 64'h1);
      wr_reg(IRQ_MASK_OFS, 8'h00);
      idle(1);
      chk("irq mask", 64'(irq), 64'h0);
      osc_on = 1'b0;
      alt_on = 1'b1;
      idle(50);
      rd_reg(IRQ_STATUS_OFS, r1);
      idle(1000);
      rdc(IRQ_STATUS_OFS, 8'h00);
      wr_reg(MAIN_CTRL_OFS, 8'hc3);
      idle(1000);
      rdc(IRQ_STATUS_OFS, 8'h01);
      wr_reg(MAIN_CTRL_OFS, 8'hfb);
      rd_reg(IRQ_STATUS_OFS, r1);
      idle(1200);
      rd_reg(IRQ_STATUS_OFS, r1);
      idle(1200);
      rd_reg(IRQ_STATUS_OFS, r2);
      idle(1200);
      rd_reg(IRQ_STATUS_OFS, r3);
      chk("prescale", 64'(r1[0] & r2[0]), 64'h0);
      chk("prescale", 64'(r2[0] & r3[0]), 64'h0);
      chk("frame", 64'(r1[0] | r2[0] | r3[0]), 64'h1);
      tally_and_finish();
   end
endmodule : lsw_ctrl_tb

// ### testbench/lsw_glass.sv
// Passive glass model recording pin activity
`timescale 1ns/100ps
module lsw_glass (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic [63:0] lcd_pin_in,
   input wire logic drive_in,
   input wire logic clear_in,
   output logic [63:0] hi_seen_out,
   output logic [63:0] lo_seen_out
);
   // Marks pins seen active or inactive while driven
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hi_seen_out <= '0;
         lo_seen_out <= '0;
      end else if (clear_in) begin
         hi_seen_out <= '0;
         lo_seen_out <= '0;
      end else if (drive_in) begin
         hi_seen_out <= hi_seen_out | lcd_pin_in;
         lo_seen_out <= lo_seen_out | ~lcd_pin_in;
      end
   end
endmodule : lsw_glass
